// >>> hw/exs_pkg.sv
// constants for the exception sequencer: vectors, offsets, register map
package exs_pkg;

    // ------------------------------------------------------------------
    // fixed vector slots and vector numbers
    // ------------------------------------------------------------------
    localparam logic [31:0] POR_PC_ADDR = 32'h0000_0000; // power-on initial pc word
    localparam logic [31:0] POR_SP_ADDR = 32'h0000_0004; // power-on initial sp word
    localparam logic [31:0] MAN_PC_ADDR = 32'h0000_0008; // manual reset initial pc word
    localparam logic [31:0] MAN_SP_ADDR = 32'h0000_000c; // manual reset initial sp word
    localparam logic [7:0] VEC_GEN_ILLEGAL = 8'h04; // undefined code outside a slot
    localparam logic [7:0] VEC_SLOT_ILLEGAL = 8'h06; // bad code in a delay slot
    localparam logic [7:0] VEC_CPU_ADDR_ERR = 8'h09; // cpu address error
    localparam logic [7:0] VEC_DMA_ADDR_ERR = 8'h0a; // dma address error
    localparam logic [7:0] VEC_NMI = 8'h0b; // non-maskable interrupt
    localparam logic [7:0] VEC_USER_BREAK = 8'h0c; // user break
    localparam logic [7:0] VEC_TRAP_FIRST = 8'h20; // first trap vector
    localparam logic [7:0] VEC_TRAP_LAST = 8'h3f; // last trap vector
    localparam logic [31:0] STACK_STEP = 32'h0000_0004; // predecrement per push

    // ------------------------------------------------------------------
    // status word layout and reset values
    // ------------------------------------------------------------------
    localparam int MASK_LSB = 4; // int_mask_field bit 4
    localparam int MASK_MSB = 7; // int_mask_field bit 7
    localparam logic [3:0] MASK_ALL = 4'hf; // mask written by a reset
    localparam logic [31:0] VBR_RESET = 32'h0000_0000; // vector base after reset

    // ------------------------------------------------------------------
    // register map (ahb-lite word offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_EVT_STATUS = 8'h00; // sticky events, write one to clear
    localparam logic [7:0] OFS_EVT_MASK = 8'h04; // interrupt enables, same layout
    localparam logic [7:0] OFS_VBR = 8'h08; // vector base register
    localparam logic [7:0] OFS_LAST_VEC = 8'h0c; // last vector and busy flag

    // ------------------------------------------------------------------
    // event bits
    // ------------------------------------------------------------------
    localparam int EVT_W = 7; // number of event bits
    localparam int EVT_POR = 0; // power-on reset handled
    localparam int EVT_MAN = 1; // manual reset handled
    localparam int EVT_ADDR = 2; // address error handled
    localparam int EVT_INT = 3; // interrupt handled
    localparam int EVT_TRAP = 4; // trap handled
    localparam int EVT_GILL = 5; // general illegal handled
    localparam int EVT_SILL = 6; // slot illegal handled
    localparam logic [EVT_W-1:0] EVT_RESET = 7'h00; // status and mask reset value

    // ------------------------------------------------------------------
    // exception kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {KIND_POR, KIND_MAN, KIND_ADDR, KIND_INT,
                              KIND_TRAP, KIND_GILL, KIND_SILL} exs_kind_t;

endpackage : exs_pkg

// >>> hw/exs_sequencer.sv
// exception sequencer: detects, prioritises and sequences cpu exceptions
//
// How it works
// - reset rise with nmi high starts power-on
// - reset rise with nmi low starts manual
// - address error, interrupt wait for execution end
// - executing trap instruction starts trap handling
// - undefined code outside slot: general illegal
// - undefined or pc-changing code in slot: slot illegal
// - power-on loads pc, sp from words 0, 4
// - manual reset loads pc, sp from 8, c
// - resets clear vector base, set mask ones
// - other exceptions push status and pc on stack
// - interrupt copies its level into mask field
// - other exceptions keep the mask field unchanged
// - after stacking, fetch handler address and jump
// - each source has its own vector, slot times four
// - vectors 4,6,9,10,11,12 and 32-63 assigned
// - resets absolute, others at base plus four times vector
// - priority resets, address errors, interrupts, instructions
module exs_sequencer
(
    input wire logic clock,
    input wire logic rstn,
    // pins from outside the clock domain
    input wire logic reset_pin_n,
    input wire logic nmi_pin,
    // instruction decoder
    input wire logic dec_valid,
    input wire logic dec_undefined,
    input wire logic dec_in_delay_slot,
    input wire logic dec_pc_modifying,
    input wire logic exec_done,
    input wire logic exec_trap,
    input wire logic [7:0] trap_always_instruction,
    input wire logic [31:0] return_pc,
    // exception sources
    input wire logic cpu_addr_err,
    input wire logic dma_addr_err,
    input wire logic int_req,
    input wire logic [3:0] int_level,
    input wire logic [7:0] int_vector,
    output logic int_ack,
    // cpu register state
    input wire logic [31:0] status_word,
    input wire logic [31:0] stack_pointer_gpr,
    output logic [31:0] new_pc,
    output logic [31:0] new_sp,
    output logic [31:0] new_status_word,
    output logic cpu_load,
    output logic exc_busy,
    output logic [31:0] vector_base_reg,
    // memory port for vectors and stack
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack,
    // ahb-lite register slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq
);

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic rst_meta_ff, rst_n; // reset release pair
    logic [1:0] res_sync_ff; // reset pin: [0] meta, [1] stable
    logic [1:0] nmi_sync_ff; // nmi pin: [0] meta, [1] stable
    logic res_prev_ff; // previous stable reset pin for edge detection

    // release the asynchronous reset through two flops
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // pins arrive from outside the clock domain
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // reset pin copies start at its idle high level, so that leaving
            // reset with the pin already high is not taken as a rise
            res_sync_ff <= 2'h3;
            nmi_sync_ff <= 2'h0;
            res_prev_ff <= 1'b1;
        end
        else
        begin
            res_sync_ff <= {res_sync_ff[0], reset_pin_n};
            nmi_sync_ff <= {nmi_sync_ff[0], nmi_pin};
            res_prev_ff <= res_sync_ff[1];
        end
    end

    // rise of the reset pin, judged on the stable copies only
    logic res_rise;
    assign res_rise = res_sync_ff[1] && !res_prev_ff;

    // ------------------------------------------------------------------
    // source detection
    // ------------------------------------------------------------------
    logic [3:0] cur_mask; // mask field of the live status word
    logic int_take; // interrupt level beats the mask
    logic gill_det, sill_det; // instruction faults at decode
    assign cur_mask = status_word[exs_pkg::MASK_MSB:exs_pkg::MASK_LSB];
    assign int_take = int_req && (int_level > cur_mask);
    assign gill_det = dec_valid && dec_undefined && !dec_in_delay_slot;
    assign sill_det = dec_valid && dec_in_delay_slot
                      && (dec_undefined || dec_pc_modifying);

    // pending latches: resets hold until taken, address errors too
    logic por_pend_ff, man_pend_ff, cae_pend_ff, dae_pend_ff;

    typedef enum {ST_IDLE, ST_RST_PC, ST_RST_SP, ST_PUSH_SR, ST_PUSH_PC,
                  ST_FETCH_VEC, ST_FINISH} exs_state_t;
    exs_state_t state_ff;
    logic start; // a new exception is taken this cycle
    exs_pkg::exs_kind_t nxt_kind;
    logic [7:0] nxt_vec;

    // priority pick among the sources
    always_comb
    begin
        start = 1'b0;
        nxt_kind = exs_pkg::KIND_TRAP;
        nxt_vec = exs_pkg::VEC_TRAP_FIRST;
        if (state_ff == ST_IDLE)
        begin
            if (por_pend_ff)
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_POR;
            end
            else if (man_pend_ff)
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_MAN;
            end
            else if (exec_done && (cae_pend_ff || dae_pend_ff))
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_ADDR;
                nxt_vec = cae_pend_ff ? exs_pkg::VEC_CPU_ADDR_ERR
                                      : exs_pkg::VEC_DMA_ADDR_ERR;
            end
            else if (exec_done && int_take)
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_INT;
                nxt_vec = int_vector;
            end
            else if (exec_trap)
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_TRAP;
                nxt_vec = trap_always_instruction;
            end
            else if (sill_det)
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_SILL;
                nxt_vec = exs_pkg::VEC_SLOT_ILLEGAL;
            end
            else if (gill_det)
            begin
                start = 1'b1;
                nxt_kind = exs_pkg::KIND_GILL;
                nxt_vec = exs_pkg::VEC_GEN_ILLEGAL;
            end
        end
    end

    // pending flags: a new arrival wins over the take that clears it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_pend_ff <= 1'b0;
            man_pend_ff <= 1'b0;
            cae_pend_ff <= 1'b0;
            dae_pend_ff <= 1'b0;
        end
        else
        begin
            if (res_rise && nmi_sync_ff[1])
                por_pend_ff <= 1'b1;
            else if (start && nxt_kind == exs_pkg::KIND_POR)
                por_pend_ff <= 1'b0;
            if (res_rise && !nmi_sync_ff[1])
                man_pend_ff <= 1'b1;
            else if (start && nxt_kind == exs_pkg::KIND_MAN)
                man_pend_ff <= 1'b0;
            if (cpu_addr_err)
                cae_pend_ff <= 1'b1;
            else if (start && nxt_vec == exs_pkg::VEC_CPU_ADDR_ERR
                     && nxt_kind == exs_pkg::KIND_ADDR)
                cae_pend_ff <= 1'b0;
            if (dma_addr_err)
                dae_pend_ff <= 1'b1;
            else if (start && nxt_vec == exs_pkg::VEC_DMA_ADDR_ERR
                     && nxt_kind == exs_pkg::KIND_ADDR)
                dae_pend_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // sequencing state machine
    // ------------------------------------------------------------------
    exs_pkg::exs_kind_t kind_ff; // exception under way
    logic [7:0] vec_ff; // its vector number
    logic [3:0] level_ff; // accepted interrupt level
    logic [31:0] sp_ff, pc_ff, sr_ff; // working copies
    logic [31:0] vbr_ff; // vector base register
    logic sw_vbr_we; // software write to the vector base
    logic [31:0] sw_vbr_data;

    // slot address: base plus four times the vector number
    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] vec);
        vec_addr = base + {22'h0, vec, 2'h0};
    endfunction : vec_addr

    // handler path: stack, then the vector slot; resets: two fixed slots
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            kind_ff <= exs_pkg::KIND_POR;
            vec_ff <= 8'h00;
            level_ff <= 4'h0;
            sp_ff <= 32'h0000_0000;
            pc_ff <= 32'h0000_0000;
            sr_ff <= 32'h0000_0000;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (start)
                    begin
                        kind_ff <= nxt_kind;
                        vec_ff <= nxt_vec;
                        level_ff <= int_level;
                        sr_ff <= status_word;
                        pc_ff <= return_pc;
                        sp_ff <= stack_pointer_gpr;
                        if (nxt_kind == exs_pkg::KIND_POR || nxt_kind == exs_pkg::KIND_MAN)
                            state_ff <= ST_RST_PC;
                        else
                            state_ff <= ST_PUSH_SR;
                    end
                ST_RST_PC:
                    if (mem_ack)
                    begin
                        pc_ff <= mem_rdata;
                        state_ff <= ST_RST_SP;
                    end
                ST_RST_SP:
                    if (mem_ack)
                    begin
                        sp_ff <= mem_rdata;
                        sr_ff[exs_pkg::MASK_MSB:exs_pkg::MASK_LSB] <= exs_pkg::MASK_ALL;
                        state_ff <= ST_FINISH;
                    end
                ST_PUSH_SR:
                    if (mem_ack)
                    begin
                        sp_ff <= sp_ff - exs_pkg::STACK_STEP;
                        state_ff <= ST_PUSH_PC;
                    end
                ST_PUSH_PC:
                    if (mem_ack)
                    begin
                        sp_ff <= sp_ff - exs_pkg::STACK_STEP;
                        if (kind_ff == exs_pkg::KIND_INT)
                            sr_ff[exs_pkg::MASK_MSB:exs_pkg::MASK_LSB] <= level_ff;
                        state_ff <= ST_FETCH_VEC;
                    end
                ST_FETCH_VEC:
                    if (mem_ack)
                    begin
                        pc_ff <= mem_rdata;
                        state_ff <= ST_FINISH;
                    end
                ST_FINISH:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // memory request: one word per step, held until acknowledged
    always_comb
    begin
        mem_req = 1'b1;
        mem_we = 1'b0;
        mem_addr = 32'h0000_0000;
        mem_wdata = 32'h0000_0000;
        unique case (state_ff)
            ST_RST_PC:
                mem_addr = (kind_ff == exs_pkg::KIND_POR) ? exs_pkg::POR_PC_ADDR
                                                          : exs_pkg::MAN_PC_ADDR;
            ST_RST_SP:
                mem_addr = (kind_ff == exs_pkg::KIND_POR) ? exs_pkg::POR_SP_ADDR
                                                          : exs_pkg::MAN_SP_ADDR;
            ST_PUSH_SR:
            begin
                mem_we = 1'b1;
                mem_addr = sp_ff - exs_pkg::STACK_STEP;
                mem_wdata = sr_ff;
            end
            ST_PUSH_PC:
            begin
                mem_we = 1'b1;
                mem_addr = sp_ff - exs_pkg::STACK_STEP;
                mem_wdata = pc_ff;
            end
            ST_FETCH_VEC:
                mem_addr = vec_addr(vbr_ff, vec_ff);
            default:
                mem_req = 1'b0;
        endcase
    end

    // vector base: a reset clears it, software may load it otherwise
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            vbr_ff <= exs_pkg::VBR_RESET;
        else if (state_ff == ST_RST_SP && mem_ack)
            vbr_ff <= exs_pkg::VBR_RESET;
        else if (sw_vbr_we)
            vbr_ff <= sw_vbr_data;
    end

    // results to the cpu: loaded on the finishing cycle only
    assign cpu_load = (state_ff == ST_FINISH);
    assign exc_busy = (state_ff != ST_IDLE);
    assign int_ack = start && (nxt_kind == exs_pkg::KIND_INT);
    assign new_pc = pc_ff;
    assign new_sp = sp_ff;
    assign new_status_word = sr_ff;
    assign vector_base_reg = vbr_ff;

    // ------------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ------------------------------------------------------------------
    logic dp_wr_ff, dp_rd_ff; // data phase pending
    logic [7:0] dp_ofs_ff; // latched word offset
    logic [exs_pkg::EVT_W-1:0] evt_ff, evt_mask_ff; // sticky events and enables
    logic [exs_pkg::EVT_W-1:0] evt_set;
    logic addr_ok;
    assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2) && (haddr[31:4] == 28'h0);

    // capture the address phase
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dp_wr_ff <= 1'b0;
            dp_rd_ff <= 1'b0;
            dp_ofs_ff <= 8'h00;
        end
        else if (hready)
        begin
            dp_wr_ff <= addr_ok && hwrite;
            dp_rd_ff <= addr_ok && !hwrite;
            dp_ofs_ff <= haddr[7:0];
        end
    end

    assign sw_vbr_we = dp_wr_ff && (dp_ofs_ff == exs_pkg::OFS_VBR);
    assign sw_vbr_data = hwdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // one event per finished exception
    always_comb
    begin
        evt_set = '0;
        if (state_ff == ST_FINISH)
            evt_set[kind_ff] = 1'b1;
    end

    // sticky status (set wins over a write-one clear) and enables
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            evt_ff <= exs_pkg::EVT_RESET;
            evt_mask_ff <= exs_pkg::EVT_RESET;
        end
        else
        begin
            if (dp_wr_ff && dp_ofs_ff == exs_pkg::OFS_EVT_STATUS)
                evt_ff <= (evt_ff & ~hwdata[exs_pkg::EVT_W-1:0]) | evt_set;
            else
                evt_ff <= evt_ff | evt_set;
            if (dp_wr_ff && dp_ofs_ff == exs_pkg::OFS_EVT_MASK)
                evt_mask_ff <= hwdata[exs_pkg::EVT_W-1:0];
        end
    end

    assign irq = |(evt_ff & evt_mask_ff);

    // read mux; unmapped offsets read zero
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (dp_rd_ff)
        begin
            unique case (dp_ofs_ff)
                exs_pkg::OFS_EVT_STATUS: hrdata = {25'h0, evt_ff};
                exs_pkg::OFS_EVT_MASK: hrdata = {25'h0, evt_mask_ff};
                exs_pkg::OFS_VBR: hrdata = vbr_ff;
                exs_pkg::OFS_LAST_VEC: hrdata = {23'h0, exc_busy, vec_ff};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_push_sr;
        state_ff == ST_PUSH_SR && mem_ack;
    endsequence
    sequence s_push_pc;
        state_ff == ST_PUSH_PC && mem_ack;
    endsequence

    AST_POR_START: assert property (@(posedge clock) disable iff (!rst_n)
        res_rise && nmi_sync_ff[1] |=> por_pend_ff || kind_ff == exs_pkg::KIND_POR)
        else $error("power-on reset not started");
    AST_MAN_START: assert property (@(posedge clock) disable iff (!rst_n)
        res_rise && !nmi_sync_ff[1] |=> man_pend_ff)
        else $error("manual reset not pending");
    AST_ADDR_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
        start && nxt_kind inside {exs_pkg::KIND_ADDR, exs_pkg::KIND_INT} |-> exec_done)
        else $error("address error or interrupt started mid execution");
    AST_RST_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
        state_ff == ST_RST_PC && kind_ff == exs_pkg::KIND_POR |-> mem_addr == 32'h0)
        else $error("power-on pc fetched from wrong slot");
    AST_RST_MASK: assert property (@(posedge clock) disable iff (!rst_n)
        state_ff == ST_RST_SP && mem_ack |=> vbr_ff == 32'h0 && sr_ff[7:4] == 4'hf)
        else $error("reset did not clear base or set mask");
    AST_STACK_ORDER: assert property (@(posedge clock) disable iff (!rst_n)
        s_push_sr |=> state_ff == ST_PUSH_PC && mem_addr == $past(sp_ff) - 32'h8)
        else $error("pc push not below status push");
    AST_INT_MASK: assert property (@(posedge clock) disable iff (!rst_n)
        s_push_pc and (kind_ff == exs_pkg::KIND_INT) |=> sr_ff[7:4] == $past(level_ff))
        else $error("interrupt level not copied to mask");
    AST_KEEP_MASK: assert property (@(posedge clock) disable iff (!rst_n)
        s_push_pc and (kind_ff != exs_pkg::KIND_INT) |=> $stable(sr_ff[7:4]))
        else $error("mask changed by non interrupt exception");
    AST_VEC_ADDR: assert property (@(posedge clock) disable iff (!rst_n)
        state_ff == ST_FETCH_VEC |-> mem_addr == vbr_ff + 32'(vec_ff) * 4)
        else $error("vector slot address wrong");
    AST_SLOT_ILL: assert property (@(posedge clock) disable iff (!rst_n)
        start && nxt_kind == exs_pkg::KIND_SILL |=> vec_ff == 8'h06 && state_ff == ST_PUSH_SR)
        else $error("slot illegal vector wrong");

endmodule : exs_sequencer

// >>> tb/exs_mem_model.sv
// vector and stack memory model that answers after a random wait
module exs_mem_model
(
    input wire logic clock,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
timeunit 1ns;
timeprecision 1ps;
// ------------------------------------------------------------------
// wait counter and answer
// ------------------------------------------------------------------
logic [1:0] wait_ff = 2'h0; // cycles left before the answer
integer mseed = 4; // fixed seed for the wait lengths
// every word reads as its address scrambled, so each vector is known
assign mem_ack = mem_req && wait_ff == 2'h0;
// outside an answer the data lines show the inverse, never a stale word
assign mem_rdata = mem_ack ? mem_addr ^ 32'h5a5a_0000 : ~(mem_addr ^ 32'h5a5a_0000);
// reload a fresh wait after each answer or while idle
always @(posedge clock)
begin
    wait_ff <= (mem_ack || !mem_req) ? 2'($random(mseed)) : wait_ff - 2'h1;
end
endmodule : exs_mem_model

// >>> tb/exs_sequencer_test.sv
// self-checking bench for the exception sequencer
module exs_sequencer_test;
timeunit 1ns;
timeprecision 1ps;
// ------------------------------------------------------------------
// signals
// ------------------------------------------------------------------
logic clock = 0, rstn = 0, reset_pin_n = 0, nmi_pin = 1, exec_done = 0, int_req = 0;
logic [6:0] st = 0; // trap, valid, undef, slot, pcmod, cpu err, dma err
logic [7:0] tv = 8'h20, vv [6] = '{8'h20, 8'h04, 8'h06, 8'h06, 8'h09, 8'h0a};
logic [6:0] sv [6] = '{7'h40, 7'h30, 7'h38, 7'h2c, 7'h02, 7'h01};
logic [31:0] return_pc = 0, haddr = 0, hwdata = 0, mem_rdata, new_pc, new_sp, new_status_word;
logic [31:0] vector_base_reg, mem_addr, mem_wdata, hrdata;
logic [1:0] htrans = 0;
logic hsel = 0, hwrite = 0, mem_ack, int_ack, cpu_load, exc_busy, mem_req, mem_we;
logic hreadyout, hresp, irq;
logic [95:0] q [$]; // expected {pc, sp, status} per sequence
integer seed = 4, n_fail = 0, n_tests = 0, cyc = 0;
exs_sequencer i_exs_sequencer (.exec_trap(st[6]), .dec_valid(st[5]), .dec_undefined(st[4]),
    .dec_in_delay_slot(st[3]), .dec_pc_modifying(st[2]), .cpu_addr_err(st[1]),
    .dma_addr_err(st[0]), .trap_always_instruction(tv), .int_level(4'h5), .int_vector(8'h0b),
    .status_word(32'h0000_0330), .stack_pointer_gpr(32'h0000_1000), .hsize(3'h2),
    .hready(hreadyout), .*);
exs_mem_model i_exs_mem_model (.*);
// ------------------------------------------------------------------
// clock, timeout, interrupt release and sequence monitor
// ------------------------------------------------------------------
initial forever #10 clock = ~clock;
always @(posedge clock)
begin
    cyc = cyc + 1;
    if (cyc == 5000) begin n_fail = n_fail + 1; give_verdict(); end
    if (int_ack === 1'b1) int_req <= 0; // source drops once taken
    if (cpu_load === 1'b1) chk({new_pc, new_sp, new_status_word}, q.pop_front());
    // stack pushes: status word at sp-4, then the return pc at sp-8
    if (mem_we === 1'b1 && mem_ack === 1'b1)
        chk({mem_addr, mem_wdata},
            mem_addr[2] ? {32'h0000_0ffc, 32'h0000_0330} : {32'h0000_0ff8, return_pc});
end
task chk(input logic [95:0] g, input logic [95:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin n_fail = n_fail + 1; $display("mismatch %0t %h %h", $time, g, e); end
endtask : chk
// one single-word transfer; read data taken at the data-phase edge
task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock) {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge clock); while (hreadyout !== 1'b1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    if (!w) chk(hrdata, d); // for a read, d is the expected word
endtask : ahb
// wait, bounded, until every expected sequence has completed
task waitq;
    for (int i = 0; i < 80 && q.size() != 0; i++) @(posedge clock);
    @(posedge clock) {st, exec_done} <= 8'h00;
endtask : waitq
task pin_reset(input logic nmi);
    @(posedge clock) {nmi_pin, reset_pin_n} <= {nmi, 1'b0};
    repeat (4) @(posedge clock);
    reset_pin_n <= 1;
    waitq();
endtask : pin_reset
task give_verdict;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask : give_verdict
// ------------------------------------------------------------------
// main sequence
// ------------------------------------------------------------------
initial
begin
    repeat (3) @(posedge clock);
    rstn <= 1;
    q.push_back({32'h5a5a_0000, 32'h5a5a_0004, 32'h0000_03f0});
    pin_reset(1);
    ahb(1, 32'h8, 32'h100);
    ahb(0, 32'h8, 32'h100);
    for (int k = 0; k < 6; k++)
    begin
        tv <= 8'h20 | 8'($random(seed) & 31);
        @(posedge clock) {st, exec_done, return_pc} <= {sv[k], 1'b1, 32'($random(seed))};
        q.push_back({(32'h100 + 4 * (k ? vv[k] : tv)) ^ 32'h5a5a_0000, 32'h0ff8, 32'h330});
        @(posedge clock) st <= 7'h00;
        waitq();
    end
    q.push_back({32'h5a5a_012c, 32'h0ff8, 32'h350});
    @(posedge clock) {int_req, exec_done} <= 2'h3;
    waitq();
    q.push_back({32'h5a5a_0008, 32'h5a5a_000c, 32'h0000_03f0});
    pin_reset(0);
    chk(vector_base_reg, 0);
    ahb(0, 32'h0, 32'h7f);
    ahb(1, 32'h4, 32'h7f);
    @(posedge clock) chk(irq, 1);
    ahb(1, 32'h0, 32'h7f);
    @(posedge clock) chk(irq, 0);
    ahb(0, 32'h0, 32'h0);
    ahb(0, 32'h10, 32'h0);
    give_verdict();
end
endmodule : exs_sequencer_test
